// ===== hw/pbc_pkg.sv
package pbc_pkg;

    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS = 4;

    // Button hold time before a press counts; least time rounds up
    localparam int unsigned DEBOUNCE_MS = 50;
    localparam int unsigned DEBOUNCE_CYCLES =
        (DEBOUNCE_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Dead time between opening one supply switch and closing the other
    localparam int unsigned BBM_NS = 100;
    localparam int unsigned BBM_CYCLES = (BBM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Cycles after reset release before pin levels are trusted
    localparam int unsigned SETTLE_CYCLES = 4;

    // Idle levels of the synchronisers at reset
    localparam logic BUTTON_IDLE = 1'b1;
    localparam logic BUS_IDLE = 1'b0;
    localparam logic ACK_IDLE = 1'b0;

    // Power states
    typedef enum logic [1:0] {
        PBC_ST_PWRUP,
        PBC_ST_OFF,
        PBC_ST_ON,
        PBC_ST_DEACT
    } pbc_state_t;

endpackage

// ===== hw/pbc_input_filter.sv
`timescale 1ns/1ps
module pbc_input_filter #(
    parameter int unsigned HOLD_CYCLES = 1,
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_pin,
    output logic o_level,
    output logic o_held_low
);
    localparam int unsigned CW = (HOLD_CYCLES > 1) ? $clog2(HOLD_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

    logic [2:0] sync_q;
    logic level_q;
    logic [CW-1:0] cnt_q;
    logic held_q;
    wire agree = (sync_q[1] == sync_q[2]);
    wire at_last = (cnt_q == LAST);

    // A zero hold would wrap to a last count of 1 and act as a hold of 2
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("pbc_input_filter: HOLD_CYCLES must be at least 1");
    end

    // Three-stage synchroniser; stage 0 feeds stage 1 only
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_q <= {3{RESET_LEVEL}};
            level_q <= RESET_LEVEL;
        end else if (i_ce) begin
            sync_q <= {sync_q[1:0], i_pin};
            if (agree) begin
                level_q <= sync_q[2];
            end
        end
    end

    // Low-time counter; any return high restarts it
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= '0;
            held_q <= 1'b0;
        end else if (i_ce) begin
            if (level_q) begin
                cnt_q <= '0;
                held_q <= 1'b0;
            end else begin
                if (!at_last) begin
                    cnt_q <= cnt_q + 1'b1;
                end
                held_q <= at_last;
            end
        end
    end

    assign o_level = level_q;
    assign o_held_low = held_q;

    property p_release_restarts;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && level_q) |=> (cnt_q == '0) && !held_q;
    endproperty
    a_release_restarts: assert property (p_release_restarts)
        else $error("hold counter not cleared on release");

endmodule // pbc_input_filter

// ===== hw/pbc_power_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Off: long button hold turns on
// - On: long hold raises held shutdown request
// - Acknowledge: card down first, then rails
// - Unconnected acknowledge follows request, immediate off
// - Power-up off unless bus supply present
// - Acknowledge without bus supply forces off
// - Bus supply forces on, ignores inputs
// - Bus removal: battery takes over, stays on
// - Prefer bus supply, break before make
// - Bus, no card supply: bypass converter
module pbc_power_ctrl #(
    parameter int unsigned DEBOUNCE_CYCLES = pbc_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned BBM_CYCLES = pbc_pkg::BBM_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_button_n,
    input wire logic i_bus_supply_in,
    input wire logic i_off_ack,
    input wire logic i_card_active,
    input wire logic i_vcc_request,
    output pbc_pkg::pbc_state_t o_state,
    output logic o_off_req,
    output logic o_card_deact,
    output logic o_logic_rail_en,
    output logic o_analog_en,
    output logic o_boost_en,
    output logic o_boost_bypass,
    output logic o_bus_sw_en,
    output logic o_bat_sw_en
);
    import pbc_pkg::*;

    localparam int unsigned BW = (BBM_CYCLES > 1) ? $clog2(BBM_CYCLES + 1) : 1;
    localparam logic [BW-1:0] BBM_LOAD = BW'(BBM_CYCLES);
    localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYCLES);

    // Counts that the logic cannot serve
    if (DEBOUNCE_CYCLES < 2 || BBM_CYCLES < 1) begin : g_bad_param
        $error("pbc_power_ctrl: DEBOUNCE_CYCLES >= 2 and BBM_CYCLES >= 1 required");
    end

    logic btn_level;
    logic btn_held;
    logic bus_level;
    logic ack_level;
    logic btn_held_q;
    pbc_state_t state_q;
    pbc_state_t state_d;
    logic off_req_q;
    logic off_req_d;
    logic card_deact_q;
    logic rail_q;
    logic boost_en_q;
    logic bypass_q;
    logic bus_sw_q;
    logic bat_sw_q;
    logic [BW-1:0] bbm_cnt_q;
    logic [SW-1:0] settle_cnt_q;

    // Button: synchronised and timed for a long hold
    pbc_input_filter #(
        .HOLD_CYCLES(DEBOUNCE_CYCLES),
        .RESET_LEVEL(BUTTON_IDLE)
    ) u_button (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_pin(i_button_n),
        .o_level(btn_level),
        .o_held_low(btn_held)
    );

    // Bus supply detect: level only
    pbc_input_filter #(
        .HOLD_CYCLES(1),
        .RESET_LEVEL(BUS_IDLE)
    ) u_bus (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_pin(i_bus_supply_in),
        .o_level(bus_level),
        .o_held_low()
    );

    // Shutdown acknowledge: level only
    pbc_input_filter #(
        .HOLD_CYCLES(1),
        .RESET_LEVEL(ACK_IDLE)
    ) u_ack (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_pin(i_off_ack),
        .o_level(ack_level),
        .o_held_low()
    );

    // One event per hold; holding on past turn-on gives no second event
    wire press_evt = btn_held && !btn_held_q;
    wire settle_done = (settle_cnt_q == SETTLE_LAST);
    wire rail_d = (state_d == PBC_ST_ON) || (state_d == PBC_ST_DEACT);
    wire bypass_d = rail_d && bus_sw_q && !i_vcc_request;
    wire boost_en_d = rail_d && !bypass_d;
    wire want_bus = bus_level;
    wire wrong_src = (bus_sw_q && !want_bus) || (bat_sw_q && want_bus);
    wire both_open = !bus_sw_q && !bat_sw_q;

    // Next power state and request
    always_comb begin
        state_d = state_q;
        off_req_d = off_req_q;
        case (state_q)
            PBC_ST_PWRUP: begin
                if (settle_done) begin
                    state_d = bus_level ? PBC_ST_ON : PBC_ST_OFF;
                end
            end
            PBC_ST_OFF: begin
                if (bus_level) begin
                    state_d = PBC_ST_ON;
                end else if (press_evt) begin
                    state_d = PBC_ST_ON;
                end
            end
            PBC_ST_ON: begin
                if (bus_level) begin
                    off_req_d = 1'b0;
                end else if (ack_level) begin
                    // Acknowledge may come unasked; an open pin follows the request
                    state_d = i_card_active ? PBC_ST_DEACT : PBC_ST_OFF;
                end else if (press_evt) begin
                    off_req_d = 1'b1;
                end
                // Bus loss alone changes nothing here
            end
            PBC_ST_DEACT: begin
                if (bus_level) begin
                    state_d = PBC_ST_ON;
                end else if (!i_card_active) begin
                    state_d = PBC_ST_OFF;
                end
            end
            default: begin
                state_d = PBC_ST_OFF;
            end
        endcase
        if (state_d == PBC_ST_OFF || state_d == PBC_ST_PWRUP) begin
            off_req_d = 1'b0;
        end
    end

    // State, request and settle counter
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= PBC_ST_PWRUP;
            off_req_q <= 1'b0;
            btn_held_q <= 1'b0;
            settle_cnt_q <= '0;
        end else if (i_ce) begin
            state_q <= state_d;
            off_req_q <= off_req_d;
            btn_held_q <= btn_held;
            if (!settle_done) begin
                settle_cnt_q <= settle_cnt_q + 1'b1;
            end
        end
    end

    // Rails and card shutdown drive; registered so the pins never glitch
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            card_deact_q <= 1'b0;
            rail_q <= 1'b0;
            boost_en_q <= 1'b0;
            bypass_q <= 1'b0;
        end else if (i_ce) begin
            card_deact_q <= (state_d == PBC_ST_DEACT);
            rail_q <= rail_d;
            boost_en_q <= boost_en_d;
            bypass_q <= bypass_d;
        end
    end

    // Source switches: open both, wait dead time, close the wanted one
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bus_sw_q <= 1'b0;
            bat_sw_q <= 1'b0;
            bbm_cnt_q <= BBM_LOAD;
        end else if (i_ce) begin
            if (wrong_src) begin
                bus_sw_q <= 1'b0;
                bat_sw_q <= 1'b0;
                bbm_cnt_q <= BBM_LOAD;
            end else if (both_open) begin
                if (bbm_cnt_q != '0) begin
                    bbm_cnt_q <= bbm_cnt_q - 1'b1;
                end else if (settle_done) begin
                    // Wait for settled pins so a present bus never loses to the battery
                    bus_sw_q <= want_bus;
                    bat_sw_q <= !want_bus;
                end
            end
        end
    end

    assign o_state = state_q;
    assign o_off_req = off_req_q;
    assign o_card_deact = card_deact_q;
    assign o_logic_rail_en = rail_q;
    assign o_analog_en = rail_q;
    assign o_boost_en = boost_en_q;
    assign o_boost_bypass = bypass_q;
    assign o_bus_sw_en = bus_sw_q;
    assign o_bat_sw_en = bat_sw_q;

    property p_off_turn_on;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == PBC_ST_OFF && !bus_level && press_evt)
            |=> state_q == PBC_ST_ON ##0 o_logic_rail_en;
    endproperty
    a_off_turn_on: assert property (p_off_turn_on)
        else $error("long press while off did not turn on");

    property p_req_raise;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == PBC_ST_ON && !bus_level && !ack_level && press_evt)
            |=> o_off_req;
    endproperty
    a_req_raise: assert property (p_req_raise)
        else $error("long press while on did not raise request");

    property p_req_held;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (o_off_req && state_q == PBC_ST_ON && !bus_level && !ack_level) |=> o_off_req;
    endproperty
    a_req_held: assert property (p_req_held)
        else $error("request dropped without acknowledge");

    property p_card_first;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == PBC_ST_ON && !bus_level && ack_level && i_card_active)
            |=> o_card_deact && o_logic_rail_en;
    endproperty
    a_card_first: assert property (p_card_first)
        else $error("rails dropped before card shutdown");

    property p_ack_off;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == PBC_ST_ON && !bus_level && ack_level && !i_card_active)
            |=> state_q == PBC_ST_OFF && !o_logic_rail_en && !o_off_req;
    endproperty
    a_ack_off: assert property (p_ack_off)
        else $error("acknowledge did not turn off");

    property p_open_ack_off;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && o_off_req && ack_level && !bus_level && !i_card_active)
            |=> state_q == PBC_ST_OFF;
    endproperty
    a_open_ack_off: assert property (p_open_ack_off)
        else $error("request with looped acknowledge did not turn off");

    property p_pwrup;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == PBC_ST_PWRUP && settle_done)
            |=> state_q == ($past(bus_level) ? PBC_ST_ON : PBC_ST_OFF);
    endproperty
    a_pwrup: assert property (p_pwrup)
        else $error("wrong state after power-up");

    property p_bus_on;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && bus_level && state_q != PBC_ST_PWRUP) |=> state_q == PBC_ST_ON;
    endproperty
    a_bus_on: assert property (p_bus_on)
        else $error("bus supply did not force on");

    property p_bus_loss_stays_on;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && state_q == PBC_ST_ON && $fell(bus_level) && !ack_level)
            |=> state_q == PBC_ST_ON ##[1:60] o_bat_sw_en;
    endproperty
    a_bus_loss_stays_on: assert property (p_bus_loss_stays_on)
        else $error("bus loss dropped power or battery not selected");

    property p_bbm;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        !(o_bus_sw_en && o_bat_sw_en) && !($rose(o_bat_sw_en) && $past(o_bus_sw_en));
    endproperty
    a_bbm: assert property (p_bbm)
        else $error("supply switches overlap");

    property p_bypass;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (i_ce && rail_d && o_bus_sw_en && !i_vcc_request)
            |=> o_boost_bypass && !o_boost_en;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("converter not bypassed on bus supply");

    property p_off_no_req;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state_q == PBC_ST_OFF) |-> !o_off_req && !o_logic_rail_en;
    endproperty
    a_off_no_req: assert property (p_off_no_req)
        else $error("request or rail high while off");

endmodule // pbc_power_ctrl

// ===== dv/pbc_host_model.sv
`timescale 1ns/1ps
module pbc_host_model #(
    parameter int unsigned ACK_DELAY = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_off_req,
    input wire logic i_card_deact,
    input wire logic i_press,
    input wire logic [1:0] i_ack_mode,
    input wire logic i_force_ack,
    input wire logic i_card_open,
    output logic o_button_n,
    output logic o_off_ack,
    output logic o_card_active
);
    logic [7:0] wait_q;
    logic ack_q;
    logic open_q;
    logic card_q;
    logic [1:0] drop_q;

    // Switch to ground, low while pressed
    assign o_button_n = ~i_press;

    // Host finishes its own work before it answers the request
    always_ff @(posedge i_ref_clk) begin
        if (!i_off_req) begin
            wait_q <= 8'h00;
            ack_q <= 1'b0;
        end else if (wait_q == 8'(ACK_DELAY)) begin
            ack_q <= 1'b1;
        end else begin
            wait_q <= wait_q + 8'h01;
        end
    end

    // Mode 0 grounded pin, 1 handshake, 2 open pin pulled to the request
    assign o_off_ack = i_force_ack |
        (i_ack_mode == 2'h2 ? i_off_req : (i_ack_mode == 2'h1) & ack_q);

    // Card sequencer: slow to drop the session once asked
    always_ff @(posedge i_ref_clk) begin
        open_q <= i_card_open;
        if (!i_card_open) begin
            card_q <= 1'b0;
            drop_q <= 2'h0;
        end else if (!open_q) begin
            card_q <= 1'b1;
        end else if (i_card_deact) begin
            drop_q <= drop_q + 2'h1;
            if (drop_q == 2'h3) begin
                card_q <= 1'b0;
            end
        end
    end
    assign o_card_active = card_q;
endmodule // pbc_host_model

// ===== dv/push_button_power_controller_tb.sv
`timescale 1ns/1ps
module push_button_power_controller_tb;
    import pbc_pkg::*;
    localparam int unsigned DEB = 16;
    localparam int unsigned BBM = 2;
    logic clk, rst_n, ce, bus, vreq, press, fack, copen;
    logic [1:0] amode;
    logic btn_n, ack, cact, req, deact, lrail, arail, boost, byp, bsw, tsw;
    pbc_state_t st;
    int num_errors = 0;
    int total_checks = 0;

    // Reference clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    pbc_host_model #(.ACK_DELAY(20)) host (
        .i_ref_clk(clk), .i_off_req(req), .i_card_deact(deact), .i_press(press),
        .i_ack_mode(amode), .i_force_ack(fack), .i_card_open(copen),
        .o_button_n(btn_n), .o_off_ack(ack), .o_card_active(cact)
    );

    pbc_power_ctrl #(.DEBOUNCE_CYCLES(DEB), .BBM_CYCLES(BBM)) dut (
        .i_ref_clk(clk), .i_resetn(rst_n), .i_ce(ce), .i_button_n(btn_n),
        .i_bus_supply_in(bus), .i_off_ack(ack), .i_card_active(cact), .i_vcc_request(vreq),
        .o_state(st), .o_off_req(req), .o_card_deact(deact), .o_logic_rail_en(lrail),
        .o_analog_en(arail), .o_boost_en(boost), .o_boost_bypass(byp), .o_bus_sw_en(bsw),
        .o_bat_sw_en(tsw)
    );

    task automatic report_and_stop;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait for a state, then compare
    task automatic wait_st(input pbc_state_t s);
        int k;
        for (k = 0; k < 300 && st !== s; k++) begin
            @(negedge clk);
        end
        check(st, s);
    endtask

    task automatic wait_req;
        int k;
        for (k = 0; k < 300 && req !== 1'b1; k++) begin
            @(negedge clk);
        end
    endtask

    task automatic drive_rst(input logic b);
        @(posedge clk);
        rst_n <= 1'b0;
        bus <= b;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic push(input logic v);
        @(posedge clk);
        press <= v;
    endtask

    // No bus at power-up: off, battery selected
    task automatic t_powerup;
        drive_rst(1'b0);
        wait_st(PBC_ST_OFF);
        cyc(BBM + 4);
        check({bsw, tsw}, 8'h01);
        check({lrail, arail, boost}, 8'h00);
    endtask

    // Two short presses split by a gap must not add up
    task automatic t_short;
        push(1'b1);
        repeat (DEB - 4) @(posedge clk);
        press <= 1'b0;
        repeat (3) @(posedge clk);
        press <= 1'b1;
        repeat (DEB - 4) @(posedge clk);
        press <= 1'b0;
        cyc(12);
        check(st, PBC_ST_OFF);
    endtask

    // Long hold turns on, never before the interval
    task automatic t_on;
        push(1'b1);
        cyc(DEB - 2);
        check(st, PBC_ST_OFF);
        wait_st(PBC_ST_ON);
        check({lrail, arail}, 8'h03);
        push(1'b0);
        cyc(6);
    endtask

    // Held request, late ack, card dropped before the rails
    task automatic t_req;
        @(posedge clk);
        amode <= 2'h1;
        copen <= 1'b1;
        t_on();
        push(1'b1);
        wait_req();
        push(1'b0);
        cyc(12);
        check({req, st}, {1'b1, PBC_ST_ON});
        wait_st(PBC_ST_DEACT);
        check({deact, lrail, arail}, 8'h07);
        wait_st(PBC_ST_OFF);
        check({req, deact, lrail, arail, boost}, 8'h00);
        @(posedge clk);
        copen <= 1'b0;
    endtask

    // Open ack pin: off right after the request
    task automatic t_float;
        @(posedge clk);
        amode <= 2'h2;
        t_on();
        push(1'b1);
        wait_req();
        cyc(7);
        check(st, PBC_ST_OFF);
        push(1'b0);
        cyc(6);
    endtask

    // Unrequested ack forces off; a low enable holds it back first
    task automatic t_force;
        @(posedge clk);
        amode <= 2'h0;
        t_on();
        @(posedge clk);
        fack <= 1'b1;
        ce <= 1'b0;
        cyc(12);
        check(st, PBC_ST_ON);
        @(posedge clk);
        ce <= 1'b1;
        cyc(8);
        check(st, PBC_ST_OFF);
        @(posedge clk);
        fack <= 1'b0;
        cyc(4);
    endtask

    // Bus supply: forced on, bypass, inputs ignored, then battery takeover
    task automatic t_bus;
        @(posedge clk);
        bus <= 1'b1;
        wait_st(PBC_ST_ON);
        cyc(BBM + 6);
        check({bsw, tsw, boost, byp}, 8'h09);
        @(posedge clk);
        vreq <= 1'b1;
        cyc(4);
        check({boost, byp}, 8'h02);
        @(posedge clk);
        vreq <= 1'b0;
        press <= 1'b1;
        fack <= 1'b1;
        cyc(DEB + 20);
        check({req, st}, {1'b0, PBC_ST_ON});
        @(posedge clk);
        press <= 1'b0;
        fack <= 1'b0;
        cyc(8);
        @(posedge clk);
        bus <= 1'b0;
        repeat (30) begin
            @(negedge clk);
            check(st, PBC_ST_ON);
        end
        check({bsw, tsw}, 8'h01);
    endtask

    // Switches never both closed
    always @(negedge clk) begin
        if (rst_n === 1'b1) begin
            check(bsw & tsw, 8'h00);
        end
    end

    // Stop a hang
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        bus = 1'b0;
        vreq = 1'b0;
        press = 1'b0;
        fack = 1'b0;
        copen = 1'b0;
        amode = 2'h1;
        t_powerup();
        t_short();
        t_req();
        t_float();
        t_force();
        t_bus();
        drive_rst(1'b1);
        wait_st(PBC_ST_ON);
        report_and_stop();
    end
endmodule // push_button_power_controller_tb
